// File: shared/qdc_pkg.sv
// constants and types shared by the quadrature down-converter files
package qdc_pkg;

   // ----------------------------------------------------------------
   // data path widths
   // ----------------------------------------------------------------
   localparam int QDC_ADC_W = 12;     // converter sample width
   localparam int QDC_OUT_W = 16;     // product, tap and result width
   localparam int QDC_REF_W = 10;     // reference wave amplitude width
   localparam int QDC_MUL_W = 22;     // full sample x reference product
   localparam int QDC_PHASE_W = 32;   // phase accumulator width
   localparam int QDC_LUT_AW = 4;     // phase bits that index the table
   localparam int QDC_COEF_W = 16;    // signed q1.15 coefficient
   localparam int QDC_ACC_W = 35;     // room for eight full products
   localparam int QDC_TAPS = 8;       // filter length
   localparam int QDC_TAP_AW = 3;     // coefficient address width

   // ----------------------------------------------------------------
   // field positions for rescaling
   // ----------------------------------------------------------------
   localparam int QDC_PROD_HI = 20;   // drop the redundant sign bit
   localparam int QDC_PROD_LO = 5;
   localparam int QDC_ACC_HI = 30;    // q1.15 gain back to unity
   localparam int QDC_ACC_LO = 15;
   localparam int QDC_LP_PAD = 4;     // low-pass path scales sample up

   // ----------------------------------------------------------------
   // decimation and reset values
   // ----------------------------------------------------------------
   localparam int QDC_DECIM = 4;
   localparam logic [1:0] QDC_DEC_LAST = 2'h3;       // last phase of four
   localparam logic [3:0] QDC_QUARTER = 4'h4;        // 90 degrees in the table
   localparam logic [31:0] QDC_PHASE_RST = 32'h0;
   localparam logic [15:0] QDC_COEF_RST = 16'h1000;  // 1/8 each, unity dc gain
   localparam int QDC_FIFO_DEPTH = 4;
   localparam int QDC_FIFO_W = 32;                   // i in top half, q in low

   // one full period of the reference, 16 points, amplitude 511
   localparam logic [9:0] QDC_SIN_LUT [16] = '{
      10'h000, 10'h0C4, 10'h169, 10'h1D8, 10'h1FF, 10'h1D8, 10'h169, 10'h0C4,
      10'h000, 10'h33C, 10'h297, 10'h228, 10'h201, 10'h228, 10'h297, 10'h33C
   };

   // ----------------------------------------------------------------
   // function select
   // ----------------------------------------------------------------
   typedef enum logic {
      QDC_MODE_LOWPASS = 1'b0,
      QDC_MODE_DOWNCONV = 1'b1
   } qdc_mode_t;

endpackage

// File: hdl/qdc_fifo.sv
// result fifo with a registered read stage
module qdc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);

   // ----------------------------------------------------------------
   // storage and pointers
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] mem [DEPTH];        // ring storage
   logic [AW-1:0] wr_reg, wr_next;       // write pointer
   logic [AW-1:0] rd_reg, rd_next;       // read pointer
   logic [AW:0] cnt_reg, cnt_next;       // words in the ring
   logic out_v_reg, out_v_next;          // read stage holds a word
   logic [WIDTH-1:0] out_d_reg, out_d_next;
   logic wr;
   logic pop;

   // honest full: the ring refuses once every slot is taken
   assign o_in_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign o_out_valid = out_v_reg;
   assign o_out_data = out_d_reg;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      wr = i_ce & i_in_valid & o_in_ready;
      // refill the read stage when empty or being taken
      pop = i_ce & (cnt_reg != '0) & (~out_v_reg | i_out_ready);
      wr_next = wr ? wr_reg + 1'b1 : wr_reg;
      rd_next = pop ? rd_reg + 1'b1 : rd_reg;
      cnt_next = cnt_reg + (AW+1)'(wr) - (AW+1)'(pop);
      out_v_next = out_v_reg;
      out_d_next = out_d_reg;
      if (pop) begin
         out_v_next = 1'b1;
         out_d_next = mem[rd_reg];
      end else if (i_ce & i_out_ready) begin
         // word taken and nothing behind it
         out_v_next = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         out_v_reg <= 1'b0;
         out_d_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
         out_v_reg <= out_v_next;
         out_d_reg <= out_d_next;
      end
   end

   // storage has no reset: contents are only read after a write
   always_ff @(posedge i_clk) begin
      if (wr) begin
         mem[wr_reg] <= i_in_data;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   // an offered pair holds until taken, so i and q never split
   property p_out_hold;
      o_out_valid && !(i_ce && i_out_ready) |=> o_out_valid && $stable(o_out_data);
   endproperty
   a_out_hold: assert property (p_out_hold) else $error("fifo output changed"); // RULE_10

   // a full ring that is not drained must not take another word
   property p_full_refuse;
      cnt_reg == (AW+1)'(DEPTH) && !pop |-> !o_in_ready ##1 cnt_reg == (AW+1)'(DEPTH);
   endproperty
   a_full_refuse: assert property (p_full_refuse) else $error("fifo accepted when full");
endmodule

// File: hdl/qdc_top.sv
// quadrature down-converter between converter samples and capture memory
// Notes on behaviour
// [RULE_01] filter every converter sample directly, no raw buffering
// [RULE_02] low-pass or down-convert, both continuous
// [RULE_03] controller sets reference increment before capture
// [RULE_04] new cosine/sine pair on every sample
// [RULE_05] multiply each sample by cosine and sine
// [RULE_06] fir low-pass each stream, programmable coefficients
// [RULE_07] keep every fourth filtered result only
// [RULE_08] converter runs four times the output rate
// [RULE_09] result rate equals the requested output rate
// [RULE_10] equal-length real and imaginary records, paired
// [RULE_11] content near reference shifts to baseband
// [RULE_12] phase accumulator drives quadrature references
module qdc_top (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic i_adc_valid,
   input wire logic [11:0] i_adc_data,
   output logic o_adc_ready,
   input wire logic i_mode,
   input wire logic [31:0] i_ref_incr,
   input wire logic i_coef_wr,
   input wire logic [2:0] i_coef_addr,
   input wire logic [15:0] i_coef_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [15:0] o_out_i,
   output logic [15:0] o_out_q
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   localparam int TAPS = qdc_pkg::QDC_TAPS;
   logic adv;                                  // one sample moves the pipe
   logic push;                                 // decimated pair to fifo
   logic fifo_ready;                           // back-pressure from fifo
   logic [31:0] phase_reg, phase_next;         // reference phase
   logic [3:0] lut_idx;                        // table index of phase
   logic signed [9:0] sin_ref, cos_ref;        // current references
   logic signed [21:0] mul_i, mul_q;           // raw products
   logic signed [15:0] prod_i_reg, prod_i_next;
   logic signed [15:0] prod_q_reg, prod_q_next;
   logic signed [15:0] tap_i_reg [TAPS];       // in-phase delay line
   logic signed [15:0] tap_i_next [TAPS];
   logic signed [15:0] tap_q_reg [TAPS];       // quadrature delay line
   logic signed [15:0] tap_q_next [TAPS];
   logic signed [15:0] coef_reg [TAPS];        // shared coefficient set
   logic signed [15:0] coef_next [TAPS];
   logic [1:0] dec_reg, dec_next;              // decimation phase
   logic signed [34:0] acc_i, acc_q;           // filter sums
   logic signed [31:0] tp_i, tp_q;             // one full tap product each
   logic [31:0] fifo_in;                       // packed i/q pair
   logic [31:0] fifo_out;

   // ----------------------------------------------------------------
   // reference generation
   // ----------------------------------------------------------------
   // table lookup; cosine is the same table a quarter turn ahead
   always_comb begin
      lut_idx = phase_reg[31:28];
      sin_ref = $signed(qdc_pkg::QDC_SIN_LUT[lut_idx]); // RULE_12
      cos_ref = $signed(qdc_pkg::QDC_SIN_LUT[4'(lut_idx + qdc_pkg::QDC_QUARTER)]);
      // mixing moves content near the reference to dc
      mul_i = $signed(i_adc_data) * cos_ref; // RULE_05 RULE_11
      mul_q = $signed(i_adc_data) * sin_ref; // RULE_05
   end

   // ----------------------------------------------------------------
   // sample advance
   // ----------------------------------------------------------------
   // whole pipe steps per sample; a full fifo stalls the source
   always_comb begin
      adv = i_ce & i_adc_valid & fifo_ready; // RULE_01
      push = adv & (dec_reg == qdc_pkg::QDC_DEC_LAST); // RULE_07 RULE_08
   end
   assign o_adc_ready = fifo_ready;

   // ----------------------------------------------------------------
   // mixer, delay lines, decimation: next values
   // ----------------------------------------------------------------
   always_comb begin
      phase_next = phase_reg;
      prod_i_next = prod_i_reg;
      prod_q_next = prod_q_reg;
      tap_i_next = tap_i_reg;
      tap_q_next = tap_q_reg;
      dec_next = dec_reg;
      if (adv) begin
         // increment is supplied by the controller beforehand
         phase_next = phase_reg + i_ref_incr; // RULE_03 RULE_04 RULE_12
         if (i_mode == qdc_pkg::QDC_MODE_DOWNCONV) begin
            prod_i_next = mul_i[qdc_pkg::QDC_PROD_HI:qdc_pkg::QDC_PROD_LO]; // RULE_05
            prod_q_next = mul_q[qdc_pkg::QDC_PROD_HI:qdc_pkg::QDC_PROD_LO];
         end else begin
            // plain low-pass: sample straight in, q stream held at zero
            prod_i_next = {i_adc_data, 4'h0}; // RULE_02
            prod_q_next = '0;
         end
         // products enter the filter the next sample, never queued
         tap_i_next[0] = prod_i_reg; // RULE_01 RULE_06
         tap_q_next[0] = prod_q_reg;
         for (int k = 1; k < TAPS; k++) begin
            tap_i_next[k] = tap_i_reg[k-1];
            tap_q_next[k] = tap_q_reg[k-1];
         end
         // wraps at four, counting converter samples only
         dec_next = dec_reg + 2'h1; // RULE_07 RULE_09
      end
   end

   // ----------------------------------------------------------------
   // coefficient array: next values
   // ----------------------------------------------------------------
   // writes may land mid-capture; the next sum uses the new value
   always_comb begin
      coef_next = coef_reg;
      if (i_ce & i_coef_wr) begin
         coef_next[i_coef_addr] = $signed(i_coef_data); // RULE_06
      end
   end

   // ----------------------------------------------------------------
   // filter sums
   // ----------------------------------------------------------------
   // only every fourth sum is used, so a full parallel sum is a waste
   // of multipliers traded for no extra control logic
   always_comb begin
      acc_i = '0;
      acc_q = '0;
      tp_i = '0;
      tp_q = '0;
      for (int k = 0; k < TAPS; k++) begin
         // product formed at full width first, so no high bits are lost
         tp_i = tap_i_reg[k] * coef_reg[k];
         tp_q = tap_q_reg[k] * coef_reg[k];
         acc_i = acc_i + 35'(tp_i); // RULE_06
         acc_q = acc_q + 35'(tp_q);
      end
      // one word per step carries both records together
      fifo_in = {acc_i[qdc_pkg::QDC_ACC_HI:qdc_pkg::QDC_ACC_LO],
                 acc_q[qdc_pkg::QDC_ACC_HI:qdc_pkg::QDC_ACC_LO]}; // RULE_10
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         phase_reg <= qdc_pkg::QDC_PHASE_RST;
         prod_i_reg <= '0;
         prod_q_reg <= '0;
         dec_reg <= '0;
         for (int k = 0; k < TAPS; k++) begin
            tap_i_reg[k] <= '0;
            tap_q_reg[k] <= '0;
            coef_reg[k] <= qdc_pkg::QDC_COEF_RST;
         end
      end else begin
         phase_reg <= phase_next;
         prod_i_reg <= prod_i_next;
         prod_q_reg <= prod_q_next;
         dec_reg <= dec_next;
         tap_i_reg <= tap_i_next;
         tap_q_reg <= tap_q_next;
         coef_reg <= coef_next;
      end
   end

   // ----------------------------------------------------------------
   // result buffer
   // ----------------------------------------------------------------
   qdc_fifo #(
      .WIDTH(qdc_pkg::QDC_FIFO_W),
      .DEPTH(qdc_pkg::QDC_FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_ce(i_ce),
      .i_in_valid(push),
      .o_in_ready(fifo_ready),
      .i_in_data(fifo_in),
      .o_out_valid(o_out_valid),
      .i_out_ready(i_out_ready),
      .o_out_data(fifo_out)
   );
   assign o_out_i = fifo_out[31:16];
   assign o_out_q = fifo_out[15:0];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   sequence s_quiet3;
      !push [*3];
   endsequence

   property p_phase_step;
      adv |=> phase_reg == $past(phase_reg) + $past(i_ref_incr);
   endproperty
   a_phase_step: assert property (p_phase_step) else $error("phase step wrong"); // RULE_12

   property p_ref_quad;
      phase_reg[31:28] == 4'h0 |-> sin_ref == 10'sh000 && cos_ref == 10'sh1FF;
   endproperty
   a_ref_quad: assert property (p_ref_quad) else $error("references not in quadrature"); // RULE_04

   property p_mix_zero;
      adv && i_mode == qdc_pkg::QDC_MODE_DOWNCONV && phase_reg[31:28] == 4'h8
         |=> prod_q_reg == 16'sh0000;
   endproperty
   a_mix_zero: assert property (p_mix_zero) else $error("sine product not zero"); // RULE_05

   property p_lowpass;
      adv && i_mode == qdc_pkg::QDC_MODE_LOWPASS
         |=> prod_q_reg == 16'sh0000 && prod_i_reg == {$past(i_adc_data), 4'h0};
   endproperty
   a_lowpass: assert property (p_lowpass) else $error("low-pass path wrong"); // RULE_02

   property p_tap_feed;
      adv |=> tap_i_reg[0] == $past(prod_i_reg) && tap_q_reg[0] == $past(prod_q_reg);
   endproperty
   a_tap_feed: assert property (p_tap_feed) else $error("product not fed to filter"); // RULE_01

   property p_coef_write;
      i_ce && i_coef_wr |=> coef_reg[$past(i_coef_addr)] == $signed($past(i_coef_data));
   endproperty
   a_coef_write: assert property (p_coef_write) else $error("coefficient not stored"); // RULE_06

   property p_decim;
      push |-> dec_reg == qdc_pkg::QDC_DEC_LAST && adv;
   endproperty
   a_decim: assert property (p_decim) else $error("push off decimation phase"); // RULE_07

   property p_spacing;
      push |=> s_quiet3;
   endproperty
   a_spacing: assert property (p_spacing) else $error("results closer than four samples"); // RULE_08

   property p_rate_hold;
      !adv |=> $stable(dec_reg) && $stable(phase_reg);
   endproperty
   a_rate_hold: assert property (p_rate_hold) else $error("moved without a sample"); // RULE_09
endmodule

// File: test/qdc_partner.sv
// behavioural converter source and capture memory sink
module qdc_partner (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic i_stall,
   output logic o_adc_valid,
   output logic [11:0] o_adc_data,
   input wire logic i_adc_ready,
   input wire logic i_out_valid,
   output logic o_out_ready,
   input wire logic [15:0] i_out_i,
   input wire logic [15:0] i_out_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] src_q[$];  // samples still to send
   logic [31:0] cap_q[$];  // captured pairs, real part on top
   int n_taken;            // samples the block accepted
   logic took;             // head sample went in at last edge
   initial begin
      o_adc_valid = 1'b0;
      o_adc_data = 12'h000;
      o_out_ready = 1'b0;
   end
   // ----------------------------------------------------------------
   // accept side: count samples, store pairs as capture memory does
   // ----------------------------------------------------------------
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         took <= 1'b0;
         n_taken <= 0;
         cap_q.delete();
      end else begin
         took <= o_adc_valid && i_adc_ready && i_ce;
         if (o_adc_valid && i_adc_ready && i_ce) begin
            n_taken <= n_taken + 1;
         end
         if (i_out_valid && o_out_ready && i_ce) begin
            cap_q.push_back({i_out_i, i_out_q});
         end
      end
   end
   // drive off the falling edge; samples back to back at full rate
   always @(negedge i_clk) begin
      if (took && src_q.size() > 0) begin
         void'(src_q.pop_front());
      end
      o_adc_valid = i_rstn && src_q.size() > 0;
      // idle data is the inverse of the last value, never a stale copy
      o_adc_data = (src_q.size() > 0) ? src_q[0] : ~o_adc_data;
      o_out_ready = !i_stall;
   end
endmodule

// File: test/tb.sv
// self-checking bench for the quadrature down-converter
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 0, i_rstn = 0, i_ce = 1, i_mode = 0, i_coef_wr = 0, stall = 0;
   logic [31:0] i_ref_incr = 32'h0;
   logic [2:0] i_coef_addr = 3'h0;
   logic [15:0] i_coef_data = 16'h0000;
   logic adc_valid, adc_ready, out_valid, out_ready;
   logic [11:0] adc_data;
   logic [15:0] out_i, out_q;
   int n_mismatch = 0, n_checks = 0;
   logic [15:0] cf[8];  // coefficients the block should hold
   int kind = 0;        // stimulus pattern
   initial begin
      forever #5 i_clk = ~i_clk;
   end
   qdc_top dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_adc_valid(adc_valid),
      .i_adc_data(adc_data), .o_adc_ready(adc_ready), .i_mode(i_mode),
      .i_ref_incr(i_ref_incr), .i_coef_wr(i_coef_wr), .i_coef_addr(i_coef_addr),
      .i_coef_data(i_coef_data), .o_out_valid(out_valid), .i_out_ready(out_ready),
      .o_out_i(out_i), .o_out_q(out_q));
   qdc_partner mdl (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_stall(stall),
      .o_adc_valid(adc_valid), .o_adc_data(adc_data), .i_adc_ready(adc_ready),
      .i_out_valid(out_valid), .o_out_ready(out_ready), .i_out_i(out_i), .i_out_q(out_q));
   // ----------------------------------------------------------------
   // reference arithmetic
   // ----------------------------------------------------------------
   function automatic logic [11:0] samp(int k);
      if (kind == 0) begin
         return 12'(k * 151);
      end
      return (k % 4 == 0) ? 12'h400 : (k % 4 == 2) ? 12'hC00 : 12'h000;
   endfunction
   // product of sample n; phase starts at zero and steps per sample
   function automatic logic signed [15:0] prod(int n, bit q);
      logic [31:0] ph;
      logic [3:0] ix;
      logic signed [21:0] m;
      ph = i_ref_incr * n;
      ix = q ? ph[31:28] : ph[31:28] + 4'h4;
      m = $signed(samp(n)) * $signed(qdc_pkg::QDC_SIN_LUT[ix]);
      if (i_mode == 1'b0) begin
         return q ? 16'h0000 : {samp(n), 4'h0};
      end
      return m[20:5];
   endfunction
   // pair k leaves at the taking of sample 4k+3, newest tap 4k+1
   function automatic logic [15:0] exp_out(int k, bit q);
      longint a;
      a = 0;
      for (int j = 0; j < 8; j++) begin
         if (4 * k + 1 - j >= 0) begin
            a += $signed(cf[j]) * prod(4 * k + 1 - j, q);
         end
      end
      return a[30:15];
   endfunction
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic do_reset();
      @(negedge i_clk);
      i_rstn = 1'b0;
      repeat (4) @(negedge i_clk);
      check("valid in reset", out_valid, 0);
      check("ready in reset", adc_ready, 1);
      check("result in reset", {out_i, out_q}, 0);
      i_rstn = 1'b1;
      foreach (cf[j]) cf[j] = 16'h1000;
   endtask
   task automatic load(int n);
      @(posedge i_clk);
      for (int k = 0; k < n; k++) mdl.src_q.push_back(samp(k));
   endtask
   task automatic wait_caps(int n);
      int t;
      for (t = 0; t < 400 && mdl.cap_q.size() < n; t++) @(negedge i_clk);
      if (mdl.cap_q.size() < n) begin
         n_mismatch++;
         $display("pairs missing, wanted %0d", n);
         stop_test();
      end
   endtask
   // every taken group of four gives one pair, no more
   task automatic judge(int n);
      wait_caps(n / 4);
      repeat (20) @(negedge i_clk);
      check("pair count", mdl.cap_q.size(), n / 4);
      for (int k = 0; k < n / 4; k++) begin
         check("real part", mdl.cap_q[k][31:16], exp_out(k, 0));
         check("imag part", mdl.cap_q[k][15:0], exp_out(k, 1));
      end
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_lowpass();
      do_reset();
      i_mode = 1'b0;
      kind = 0;
      load(44);
      judge(44);
      $display("test lowpass done");
   endtask
   task automatic t_coef();
      do_reset();
      for (int j = 0; j < 8; j++) begin
         cf[j] = (j % 2) ? 16'hF800 : 16'h2400;
         @(negedge i_clk);
         i_coef_wr = 1'b1;
         i_coef_addr = 3'(j);
         i_coef_data = cf[j];
      end
      @(negedge i_clk);
      i_coef_wr = 1'b0;
      load(40);
      judge(40);
      $display("test coefficients done");
   endtask
   task automatic t_down();
      logic [31:0] incs[3] = '{32'h4000_0000, 32'h1000_0000, 32'h2345_6789};
      foreach (incs[m]) begin
         do_reset();
         i_mode = 1'b1;
         kind = 1;
         i_ref_incr = incs[m];
         load(32);
         judge(32);
         if (m == 0) begin
            // tone at the reference lands on a steady baseband value
            check("baseband real", mdl.cap_q[7][31:16], 16'h1FF0);
            check("baseband imag", mdl.cap_q[7][15:0], 16'h0000);
         end
      end
      $display("test downconvert done");
   endtask
   // capture memory stalls; room is four ring words plus one output word
   task automatic t_stall();
      do_reset();
      i_mode = 1'b0;
      kind = 0;
      stall = 1'b1;
      load(28);
      repeat (5) @(negedge i_clk);
      i_ce = 1'b0;
      repeat (3) @(negedge i_clk);
      i_ce = 1'b1;
      repeat (60) @(negedge i_clk);
      check("taken while full", mdl.n_taken, 20);
      check("ready when full", adc_ready, 0);
      check("valid held", out_valid, 1);
      @(posedge i_clk);
      stall = 1'b0;
      judge(28);
      check("ready after drain", adc_ready, 1);
      $display("test stall done");
   endtask
   initial begin
      t_lowpass();
      t_coef();
      t_down();
      t_stall();
      stop_test();
   end
endmodule
